// *** src/trig_cfg.svh ***
// Constants for the dual trigger pulse generator
// Operation
// - Two trigger outputs, each with its own enable; disabled output stays low.
// - Primary frequency limited to 6..50 Hz; out-of-range writes are clamped.
// - Primary pulse width set in milliseconds, independent of frequency.
// - Pulses are active high: high for width, low for rest of period.
// - With timestamp option, primary rising-edge time becomes the result timestamp.
// - Secondary active only while primary enabled; primary off forces secondary off.
// - Secondary always repeats at the primary frequency.
// - Secondary rising edge follows primary rising edge by configured offset.
// - Secondary pulse width configured independently of primary.
// - Enabling pulse-per-second sync forces secondary output off; shared pin.
// - With pulse-per-second sync on, each sync pulse clears time counter to 0.
// - Internal time counter timestamps each captured camera frame.
`ifndef TRIG_CFG_SVH
`define TRIG_CFG_SVH
`define CLK_HZ 25000000
`define US_PER_S 1000000
`define US_PER_MS 1000
`define CYC_PER_US (`CLK_HZ / `US_PER_S)
`define FREQ_MIN 8'h06
`define FREQ_MAX 8'h32
`define FREQ_RST 8'h1e
`define PWIDTH_RST 16'h0005
`define SWIDTH_RST 16'h0005
`define OFFSET_RST 16'h0000
`define REG_CTRL 6'h00
`define REG_FREQ 6'h04
`define REG_PWIDTH 6'h08
`define REG_SWIDTH 6'h0c
`define REG_OFFSET 6'h10
`define REG_STATUS 6'h14
`define REG_TIME 6'h18
`define REG_TRIG_STAMP 6'h1c
`define REG_FRAME_STAMP 6'h20
`define CTRL_PRIM_EN 0
`define CTRL_SEC_EN 1
`define CTRL_PPS_EN 2
`define CTRL_TS_EN 3
`define DEAD_WORD 32'h0000_0000
`endif

// *** src/trig_pkg.sv ***
// Types for the dual trigger pulse generator
package trig_pkg;
  typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_HIGH} chan_state_t;
  typedef logic [31:0] word_t;
  typedef logic [5:0] addr_t;
endpackage : trig_pkg

// *** src/pulse_chan_if.sv ***
// Control and output of one trigger pulse channel
`timescale 1ns/10ps
interface pulse_chan_if;
  logic start;
  logic enable;
  logic tick;
  logic [31:0] delay_us;
  logic [31:0] width_us;
  logic pulse;
  logic rise;
  modport ctl (output start, output enable, output tick, output delay_us, output width_us,
    input pulse, input rise);
  modport chan (input start, input enable, input tick, input delay_us, input width_us,
    output pulse, output rise);
endinterface : pulse_chan_if

// *** src/pulse_chan.sv ***
// One trigger pulse channel: delay then high pulse, counted in microsecond ticks
`timescale 1ns/10ps
module pulse_chan (
  input wire logic clock,
  input wire logic arst_n,
  pulse_chan_if.chan pc
);
  import trig_pkg::*;
  chan_state_t state;
  logic [31:0] cnt;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= CH_IDLE;
      cnt <= 32'h0000_0000;
    end else if (!pc.enable) begin
      state <= CH_IDLE;
      cnt <= 32'h0000_0000;
    end else if (pc.start) begin
      if (pc.delay_us == 32'h0000_0000) begin
        state <= CH_HIGH;
        cnt <= pc.width_us;
      end else begin
        state <= CH_WAIT;
        cnt <= pc.delay_us;
      end
    end else if (pc.tick) begin
      case (state)
        CH_WAIT: begin
          if (cnt <= 32'h0000_0001) begin
            state <= CH_HIGH;
            cnt <= pc.width_us;
          end else begin
            cnt <= cnt - 32'h0000_0001;
          end
        end
        CH_HIGH: begin
          if (cnt <= 32'h0000_0001) begin
            state <= CH_IDLE;
          end
          cnt <= cnt - 32'h0000_0001;
        end
        default: state <= CH_IDLE;
      endcase
    end
  end

  // Pulse high only while in high phase with a nonzero width
  always_comb begin
    pc.pulse = (state == CH_HIGH) && (cnt != 32'h0000_0000);
    pc.rise = pc.enable && pc.start;
  end
endmodule : pulse_chan

// *** src/dual_trigger_pulse_generator.sv ***
// Dual camera trigger generator with time counter and Avalon-MM registers
`timescale 1ns/10ps
`include "trig_cfg.svh"
module dual_trigger_pulse_generator (
  input wire logic clock,
  input wire logic arst_n,
  input wire trig_pkg::addr_t address,
  input wire logic read,
  input wire logic write,
  input wire trig_pkg::word_t writedata,
  output trig_pkg::word_t readdata,
  output logic waitrequest,
  input wire logic frame_strobe,
  output logic trig_prim,
  output logic trig_sec_out,
  output logic trig_sec_oe,
  input wire logic trig_sec_in
);
  import trig_pkg::*;

  localparam int CYC_US = `CYC_PER_US;
  localparam logic [19:0] US_S = 20'(`US_PER_S);
  localparam logic [31:0] MS_US = 32'(`US_PER_MS);

  logic [3:0] ctrl;
  logic [7:0] freq;
  logic [15:0] pwidth_ms;
  logic [15:0] swidth_ms;
  logic [15:0] offset_ms;
  word_t time_us;
  word_t trig_stamp;
  word_t frame_stamp;
  logic [7:0] div_cnt;
  logic tick;
  logic [19:0] acc;
  logic [20:0] next_acc;
  logic period_start;
  logic prim_en_q;
  logic prim_new;
  logic sec_active;
  logic pps_s1;
  logic pps_s2;
  logic pps_s3;
  logic pps_edge;
  logic req;
  logic take;
  logic [31:0] lag_cyc;
  logic [31:0] lag_us;

  pulse_chan_if pch[2] ();

  // Microsecond enable pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (div_cnt == 8'(CYC_US - 1)) begin
      div_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // Phase accumulator: freq per microsecond, period wraps at one second
  always_comb begin
    next_acc = {1'b0, acc} + {13'h0000, freq};
  end

  assign prim_new = ctrl[`CTRL_PRIM_EN] && !prim_en_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 20'h0_0000;
      period_start <= 1'b0;
      prim_en_q <= 1'b0;
    end else begin
      prim_en_q <= ctrl[`CTRL_PRIM_EN];
      period_start <= 1'b0;
      if (prim_new) begin
        acc <= 20'h0_0000;
        period_start <= 1'b1;
      end else if (tick && ctrl[`CTRL_PRIM_EN]) begin
        if (next_acc >= {1'b0, US_S}) begin
          acc <= 20'(next_acc - {1'b0, US_S});
          period_start <= 1'b1;
        end else begin
          acc <= next_acc[19:0];
        end
      end
    end
  end

  assign sec_active = ctrl[`CTRL_SEC_EN] && ctrl[`CTRL_PRIM_EN] && !ctrl[`CTRL_PPS_EN];

  // Channel 0 primary, channel 1 secondary, same period start
  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      assign pch[i].start = period_start;
      assign pch[i].tick = tick;
      assign pch[i].enable = (i == 0) ? ctrl[`CTRL_PRIM_EN] : sec_active;
      assign pch[i].delay_us = (i == 0) ? 32'h0000_0000 : 32'(offset_ms) * MS_US;
      assign pch[i].width_us = 32'((i == 0) ? pwidth_ms : swidth_ms) * MS_US;
      pulse_chan u_chan (
        .clock(clock),
        .arst_n(arst_n),
        .pc(pch[i])
      );
    end
  endgenerate

  // Pin outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_prim <= 1'b0;
      trig_sec_out <= 1'b0;
      trig_sec_oe <= 1'b0;
    end else begin
      trig_prim <= pch[0].pulse && ctrl[`CTRL_PRIM_EN];
      trig_sec_out <= pch[1].pulse && sec_active;
      trig_sec_oe <= sec_active;
    end
  end

  // Sync pin synchroniser and edge detect
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pps_s1 <= 1'b0;
      pps_s2 <= 1'b0;
      pps_s3 <= 1'b0;
    end else begin
      pps_s1 <= trig_sec_in;
      pps_s2 <= pps_s1;
      pps_s3 <= pps_s2;
    end
  end

  assign pps_edge = pps_s2 && !pps_s3;

  // Time counter and timestamps
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      time_us <= 32'h0000_0000;
    end else if (ctrl[`CTRL_PPS_EN] && pps_edge) begin
      time_us <= 32'h0000_0000;
    end else if (tick) begin
      time_us <= time_us + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_stamp <= 32'h0000_0000;
      frame_stamp <= 32'h0000_0000;
    end else begin
      if (pch[0].rise) begin
        trig_stamp <= time_us;
      end
      if (frame_strobe) begin
        frame_stamp <= ctrl[`CTRL_TS_EN] ? trig_stamp : time_us;
      end
    end
  end

  // Avalon-MM slave: one wait cycle, then answer
  assign req = read || write;
  assign take = req && !waitrequest;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(req && waitrequest);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 4'h0;
      freq <= `FREQ_RST;
      pwidth_ms <= `PWIDTH_RST;
      swidth_ms <= `SWIDTH_RST;
      offset_ms <= `OFFSET_RST;
    end else if (take && write) begin
      case (address)
        `REG_CTRL: ctrl <= writedata[3:0];
        `REG_FREQ: begin
          if (writedata < 32'(`FREQ_MIN)) begin
            freq <= `FREQ_MIN;
          end else if (writedata > 32'(`FREQ_MAX)) begin
            freq <= `FREQ_MAX;
          end else begin
            freq <= writedata[7:0];
          end
        end
        `REG_PWIDTH: pwidth_ms <= writedata[15:0];
        `REG_SWIDTH: swidth_ms <= writedata[15:0];
        `REG_OFFSET: offset_ms <= writedata[15:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      case (address)
        `REG_CTRL: readdata <= {28'h000_0000, ctrl};
        `REG_FREQ: readdata <= {24'h00_0000, freq};
        `REG_PWIDTH: readdata <= {16'h0000, pwidth_ms};
        `REG_SWIDTH: readdata <= {16'h0000, swidth_ms};
        `REG_OFFSET: readdata <= {16'h0000, offset_ms};
        `REG_STATUS: readdata <= {29'h0000_0000, pps_s2, trig_sec_out, trig_prim};
        `REG_TIME: readdata <= time_us;
        `REG_TRIG_STAMP: readdata <= trig_stamp;
        `REG_FRAME_STAMP: readdata <= frame_stamp;
        default: readdata <= `DEAD_WORD;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_prim_off_low: assert property (!ctrl[`CTRL_PRIM_EN] |=> !trig_prim)
    else $error("primary pulse while disabled");
  a_freq_in_range: assert property (freq >= `FREQ_MIN && freq <= `FREQ_MAX)
    else $error("frequency outside range");
  a_sec_needs_prim: assert property (trig_sec_out |-> $past(ctrl[`CTRL_PRIM_EN]))
    else $error("secondary active without primary");
  a_pps_blocks_sec: assert property (ctrl[`CTRL_PPS_EN] |=> !trig_sec_oe && !trig_sec_out)
    else $error("secondary driven while sync enabled");
  a_pps_clears_time: assert property (ctrl[`CTRL_PPS_EN] && pps_edge |=> time_us == 0)
    else $error("time not cleared on sync pulse");
  a_trig_stamp_take: assert property (pch[0].rise |=> trig_stamp == $past(time_us))
    else $error("trigger time not captured");
  a_period_restart: assert property (prim_new |=> acc == 0 && period_start)
    else $error("period not restarted on enable");
  a_sec_same_start: assert property (pch[1].start == pch[0].start)
    else $error("secondary period differs");
  a_pps_one_edge: assert property (pps_edge |=> !pps_edge)
    else $error("sync edge longer than one cycle");
  a_bus_answer: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

  c_prim_pulse: cover property ($rose(trig_prim));
  c_sec_pulse: cover property ($rose(trig_sec_out));
  c_pps_clear: cover property (ctrl[`CTRL_PPS_EN] && pps_edge);
  c_frame_stamp: cover property (frame_strobe && ctrl[`CTRL_TS_EN]);
  c_ts_capture: cover property (pch[0].rise && ctrl[`CTRL_TS_EN]);

  a_prim_after_start: assert property ($rose(trig_prim) |-> $past(period_start, 2))
    else $error("primary rose without a period start");
  a_frame_time: assert property (
    frame_strobe && !ctrl[`CTRL_TS_EN] |=> frame_stamp == $past(time_us))
    else $error("frame stamp is not the time counter");
  a_frame_trig: assert property (
    frame_strobe && ctrl[`CTRL_TS_EN] |=> frame_stamp == $past(trig_stamp))
    else $error("frame stamp is not the trigger time");

  // Cycles from period start to secondary high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lag_cyc <= 32'h0000_0000;
      lag_us <= 32'h0000_0000;
    end else if (pch[1].rise) begin
      lag_cyc <= 32'h0000_0000;
      lag_us <= pch[1].delay_us;
    end else if (!pch[1].pulse) begin
      lag_cyc <= lag_cyc + 32'h0000_0001;
    end
  end

  a_sec_offset: assert property (
    $rose(pch[1].pulse) && lag_us != 32'h0000_0000
    |-> lag_cyc > (lag_us - 32'h0000_0001) * CYC_US && lag_cyc <= lag_us * CYC_US)
    else $error("secondary offset wrong");

  // Pulse length per channel, counted from each load of the width
  generate
    for (genvar j = 0; j < 2; j++) begin : g_span
      logic [31:0] hi_cyc;
      logic [31:0] w_us;
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          hi_cyc <= 32'h0000_0000;
          w_us <= 32'h0000_0000;
        end else begin
          if (pch[j].pulse && !period_start) begin
            hi_cyc <= hi_cyc + 32'h0000_0001;
          end else begin
            hi_cyc <= 32'h0000_0000;
          end
          if (!pch[j].pulse || period_start) begin
            w_us <= pch[j].width_us;
          end
        end
      end
      a_width_span: assert property (
        $fell(pch[j].pulse) && $past(pch[j].enable) && !$past(period_start)
        |-> hi_cyc > (w_us - 32'h0000_0001) * CYC_US && hi_cyc <= w_us * CYC_US)
        else $error("pulse width wrong");
    end
  endgenerate
endmodule : dual_trigger_pulse_generator

// *** tb/camera_model.sv ***
// Behavioural camera that exposes on each trigger rising edge
`timescale 1ns/10ps
module camera_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic trig_in,
  output int exposures
);
  logic last;
  // Sampled every clock, far faster than twice the trigger rate
  // Exposure starts on rising edge only, no pulse skipped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last <= 1'b0;
      exposures <= 0;
    end else begin
      last <= trig_in;
      if (trig_in && !last) begin
        exposures <= exposures + 1;
      end
    end
  end
endmodule : camera_model

// *** tb/tb.sv ***
// Self-checking bench for the dual trigger pulse generator
`timescale 1ns/10ps
`include "trig_cfg.svh"
module tb;
  import trig_pkg::*;
  logic clock, arst_n, read, write, frame_strobe, pps_drive;
  addr_t address;
  word_t writedata, readdata, q, r, t0;
  logic waitrequest, trig_prim, trig_sec_out, trig_sec_oe;
  wire pin;
  int fails, samples_checked, n, w, o, sw, cam0, cam1;
  assign pin = trig_sec_oe ? trig_sec_out : pps_drive;
  dual_trigger_pulse_generator dual_trigger_pulse_generator_i (.clock(clock), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .frame_strobe(frame_strobe),
    .trig_prim(trig_prim), .trig_sec_out(trig_sec_out), .trig_sec_oe(trig_sec_oe),
    .trig_sec_in(pin));
  camera_model cam_left (.clock(clock), .arst_n(arst_n), .trig_in(trig_prim), .exposures(cam0));
  camera_model cam_right (.clock(clock), .arst_n(arst_n), .trig_in(pin), .exposures(cam1));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input word_t got, input word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic in_range(input int v, input int lo, input int hi);
    check(word_t'(v >= lo && v <= hi), 32'h0000_0001);
  endtask : in_range
  task automatic bus(input logic wr, input addr_t a, input word_t d, output word_t rd);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wait_sig(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      cnt++;
    end while ((sel == 0 ? trig_prim : trig_sec_out) !== lvl && cnt < 80000);
  endtask : wait_sig
  task automatic strobe_frame();
    @(posedge clock);
    frame_strobe <= 1'b1;
    @(posedge clock);
    frame_strobe <= 1'b0;
  endtask : strobe_frame
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (95000) @(posedge clock);
    fails++;
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    frame_strobe = 1'b0;
    pps_drive = 1'b0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    bus(0, `REG_CTRL, 0, q); check(q, 32'h0000_0000);
    bus(0, `REG_FREQ, 0, q); check(q, 32'h0000_001e);
    bus(0, `REG_PWIDTH, 0, q); check(q, 32'h0000_0005);
    bus(0, `REG_SWIDTH, 0, q); check(q, 32'h0000_0005);
    bus(0, `REG_OFFSET, 0, q); check(q, 32'h0000_0000);
    bus(0, 6'h3c, 0, q); check(q, 32'h0000_0000);
    check({31'h0000_0000, trig_prim}, 32'h0000_0000);
    $display("test reset values done");
    bus(1, `REG_FREQ, 32'h0000_0002, q);
    bus(0, `REG_FREQ, 0, q); check(q, 32'h0000_0006);
    bus(1, `REG_FREQ, 32'h0000_0063, q);
    bus(0, `REG_FREQ, 0, q); check(q, 32'h0000_0032);
    $display("test frequency clamp done");
    bus(1, `REG_PWIDTH, 32'h0000_0001, q);
    bus(1, `REG_SWIDTH, 32'h0000_0002, q);
    bus(1, `REG_OFFSET, 32'h0000_0001, q);
    bus(0, `REG_TIME, 0, t0);
    bus(1, `REG_CTRL, 32'h0000_0003, q);
    wait_sig(0, 1'b1, n);
    in_range(n, 1, 8);
    fork
      begin
        wait_sig(0, 1'b0, w);
        in_range(w, 24970, 25001);
      end
      begin
        wait_sig(1, 1'b1, o);
        in_range(o, 24970, 25001);
        check({31'h0000_0000, trig_sec_oe}, 32'h0000_0001);
        wait_sig(1, 1'b0, sw);
        in_range(sw, 49970, 50001);
      end
    join
    check(word_t'(cam0), 32'h0000_0001);
    check(word_t'(cam1), 32'h0000_0001);
    $display("test pulse timing done");
    bus(1, `REG_CTRL, 32'h0000_000b, q);
    strobe_frame();
    bus(0, `REG_FRAME_STAMP, 0, q);
    bus(0, `REG_TRIG_STAMP, 0, r);
    check(q, r);
    in_range(int'(r - t0), 0, 2);
    bus(1, `REG_CTRL, 32'h0000_0003, q);
    strobe_frame();
    bus(0, `REG_FRAME_STAMP, 0, q);
    bus(0, `REG_TIME, 0, r);
    in_range(int'(r - q), 0, 3);
    $display("test timestamps done");
    bus(1, `REG_CTRL, 32'h0000_0007, q);
    repeat (2) @(posedge clock);
    check({30'h0000_0000, trig_sec_oe, trig_sec_out}, 32'h0000_0000);
    pps_drive <= 1'b1;
    repeat (100) @(posedge clock);
    bus(0, `REG_STATUS, 0, q); check(q, 32'h0000_0004);
    repeat (97) @(posedge clock);
    pps_drive <= 1'b0;
    bus(0, `REG_TIME, 0, q);
    in_range(int'(q), 7, 10);
    $display("test pulse per second done");
    bus(1, `REG_CTRL, 32'h0000_0003, q);
    repeat (2) @(posedge clock);
    check({31'h0000_0000, trig_sec_oe}, 32'h0000_0001);
    bus(1, `REG_CTRL, 32'h0000_0002, q);
    repeat (2) @(posedge clock);
    check({30'h0000_0000, trig_prim, trig_sec_oe}, 32'h0000_0000);
    $display("test primary disable done");
    final_report();
  end
endmodule : tb
